// File: core/rcs_pkg.sv
/*
  constants of the reset-source and clock-fault status block:
  register indices, field positions, reset values, event bits.
  assumes nothing; no module or timescale here.
*/
package rcs_pkg;
  // -------------------------------------------------------------
  // register map (index; byte address is four times the index)
  // -------------------------------------------------------------
  localparam logic [7:0] IDX_STATUS   = 8'h25; // reset_and_clock_status
  localparam logic [7:0] IDX_EVT_STS  = 8'h26; // sticky event status
  localparam logic [7:0] IDX_EVT_MASK = 8'h27; // event interrupt mask
  localparam logic [7:0] IDX_NONE     = 8'hff; // unmapped marker
  // -------------------------------------------------------------
  // status register fields
  // -------------------------------------------------------------
  localparam int unsigned BIT_UVRF = 4; // undervoltage_reset_flag
  localparam int unsigned BIT_CFIE = 2; // clock_fault_irq_enable
  localparam int unsigned BIT_CFD  = 1; // clock_fault_detected
  localparam int unsigned BIT_WDRF = 0; // watchdog_reset_flag
  // -------------------------------------------------------------
  // event bits, reset values, option limits
  // -------------------------------------------------------------
  localparam int unsigned EVT_W   = 3;
  localparam int unsigned EV_WDG  = 0;
  localparam int unsigned EV_CF   = 1;
  localparam int unsigned EV_UV   = 2;
  localparam logic [2:0] EVT_RST  = 3'h0;
  localparam logic [1:0] LVL_MAX  = 2'h2; // three levels: 0..2
  localparam logic [1:0] LVL_RST  = 2'h0;
  localparam logic       FLAG_RST = 1'h0;
endpackage

// File: core/rcs_regbus_if.sv
/*
  internal register strobe bundle between bus slave and core.
  assumes one clock; strobes are one-cycle pulses.
*/
`timescale 1ns/10ps
`default_nettype none
interface rcs_regbus_if;
  logic       wr;    // write strobe
  logic       rd;    // read strobe
  logic [7:0] idx;   // register index
  logic [7:0] wdata; // write data
  logic [7:0] rdata; // read data from core
  modport bus  (output wr, rd, idx, wdata, input rdata);
  modport regs (input wr, rd, idx, wdata, output rdata);
endinterface
`default_nettype wire

// File: core/rcs_sync.sv
/*
  three-flop input synchroniser with agreement filter.
  assumes inputs are asynchronous to clk_sys.
*/
`timescale 1ns/10ps
`default_nettype none
module rcs_sync #(
  parameter int unsigned W = 4
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         reset_n,
  // inputs and filtered outputs
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] s1_reg, s2_reg, s3_reg; // chain
  logic [W-1:0] out_reg, out_next;      // accepted level

  // a bit follows only when stages two and three agree
  always_comb begin
    out_next = ((s2_reg ~^ s3_reg) & s3_reg) |
               ((s2_reg ^ s3_reg) & out_reg);
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s1_reg  <= '0;
      s2_reg  <= '0;
      s3_reg  <= '0;
      out_reg <= '0;
    end else begin
      s1_reg  <= async_in;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      out_reg <= out_next;
    end
  end

  assign sync_out = out_reg;
endmodule // rcs_sync
`default_nettype wire

// File: core/rcs_ahb.sv
/*
  ahb-lite slave for the status block: one wait state per access.
  assumes single word transfers; response is always okay.
*/
`timescale 1ns/10ps
`default_nettype none
module rcs_ahb (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  // register strobes
  rcs_regbus_if.bus        rb
);
  typedef enum logic [1:0] {AHB_IDLE, AHB_ACCESS, AHB_DONE} rcs_ahb_st_t;

  rcs_ahb_st_t st_reg, st_next;  // transfer phase
  logic [7:0]  idx_reg, idx_next; // latched index
  logic        wr_reg, wr_next;   // latched direction
  logic [31:0] rd_reg, rd_next;   // read data
  logic        take;              // address phase accepted

  // word aligned, low page only; anything else is unmapped
  function automatic logic [7:0] map_idx(input logic [31:0] a);
    map_idx = (a[31:10] == 22'h0 && a[1:0] == 2'h0) ? a[9:2]
                                                   : rcs_pkg::IDX_NONE;
  endfunction

  // next phase; hsize is not checked, only words are used
  always_comb begin
    take     = hsel && htrans[1] && hready;
    st_next  = st_reg;
    idx_next = idx_reg;
    wr_next  = wr_reg;
    rd_next  = rd_reg;
    unique case (st_reg)
      AHB_IDLE, AHB_DONE: begin
        st_next = take ? AHB_ACCESS : AHB_IDLE;
        if (take) begin
          idx_next = map_idx(haddr);
          wr_next  = hwrite;
        end
      end
      AHB_ACCESS: begin
        st_next = AHB_DONE;
        if (!wr_reg) begin
          rd_next = {24'h0, rb.rdata};
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st_reg  <= AHB_IDLE;
      idx_reg <= rcs_pkg::IDX_NONE;
      wr_reg  <= 1'b0;
      rd_reg  <= 32'h0;
    end else begin
      st_reg  <= st_next;
      idx_reg <= idx_next;
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
    end
  end

  // strobes fire in the wait cycle, when hwdata stands
  assign rb.wr     = (st_reg == AHB_ACCESS) && wr_reg;
  assign rb.rd     = (st_reg == AHB_ACCESS) && !wr_reg;
  assign rb.idx    = idx_reg;
  assign rb.wdata  = hwdata[7:0];
  assign hreadyout = (st_reg != AHB_ACCESS);
  assign hresp     = 1'b0;
  assign hrdata    = rd_reg;

  one_wait_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (st_reg == AHB_ACCESS) |=> hreadyout)
    else $error("wait state longer than one cycle");
endmodule // rcs_ahb
`default_nettype wire

// File: core/rcs_top.sv
/*
  reset-source and clock-fault status block: reset flags, clock
  fault flag, undervoltage reset, interrupt, ahb-lite registers.
  assumes straps stable at reset release and a watchdog pulse
  generated on clk_sys; detector, pin and oscillator inputs are asynchronous.
*/
`timescale 1ns/10ps
`default_nettype none
// Function
// R1 - hold core reset while supply low
// R2 - drive reset pin low during undervoltage
// R3 - undervoltage sets flag; software zero clears
// R4 - flag meaningless with detector disabled
// R5 - pin or watchdog reset keeps undervoltage flag
// R6 - fault enable bit gates clock fault interrupt
// R7 - fault sets flag; read clears after recovery
// R8 - fault flag reads zero when supervisor off
// R9 - watchdog sets flag; zero or undervoltage clears
// R10 - two flags encode last reset source
// R11 - reserved status bits read zero
// R12 - keep oscillators running during reset
// R13 - threshold chosen from three strapped levels
// R14 - writing one never sets reset flags
module rcs_top (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  // undervoltage detector and reset pin
  input  wire logic        uv_below_in,
  input  wire logic        reset_pin_in,
  output logic             reset_pin_out,
  output logic             reset_pin_oe,
  // watchdog and clock supervisor
  input  wire logic        wdg_reset_pulse,
  input  wire logic        safe_osc_active,
  input  wire logic        main_osc_ok,
  // option straps
  input  wire logic        opt_uv_enable,
  input  wire logic        opt_css_enable,
  input  wire logic [1:0]  opt_uv_level,
  // outputs to the chip
  output logic             core_reset_n,
  output logic             osc_keep_run,
  output logic      [1:0]  uv_level_sel,
  output logic             irq
);
  // -------------------------------------------------------------
  // declarations
  // -------------------------------------------------------------
  rcs_regbus_if rb ();            // strobe bundle
  logic [3:0] sync_q;             // filtered pins
  logic       uv_s;               // supply below threshold
  logic       pin_s;              // reset pin level
  logic       safe_s;             // safe oscillator selected
  logic       ok_s;               // main oscillator back
  // option capture
  logic       opt_done_reg, opt_done_next;
  logic       uv_en_reg, uv_en_next;
  logic       css_en_reg, css_en_next;
  logic [1:0] lvl_reg, lvl_next;
  // edge history
  logic       uv_act_reg, uv_act_next;
  logic       safe_prev_reg, safe_prev_next;
  // status flags
  logic       uvrf_reg, uvrf_next;
  logic       wdrf_reg, wdrf_next;
  logic       cfd_reg, cfd_next;
  logic       cfie_reg, cfie_next;
  // interrupt registers
  logic [2:0] evt_sts_reg, evt_sts_next;
  logic [2:0] evt_mask_reg, evt_mask_next;
  // outputs held in flops
  logic       core_rst_n_reg, core_rst_n_next;
  logic       pin_oe_reg, pin_oe_next;
  logic       irq_reg, irq_next;
  logic       osc_run_reg;
  // decoded events and strobes
  logic       uv_now, uv_rise, cf_rise, wdg_ev;
  logic       wr_st, rd_st, wr_es, wr_em;
  logic [2:0] evt_in;

  // -------------------------------------------------------------
  // bus slave and input synchroniser
  // -------------------------------------------------------------
  rcs_ahb u_ahb (
    .clk_sys   (clk_sys),
    .reset_n   (reset_n),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .rb        (rb)
  );

  // pin reads low until filled: core stays in reset a few cycles
  rcs_sync #(.W(4)) u_sync (
    .clk_sys  (clk_sys),
    .reset_n  (reset_n),
    .async_in ({main_osc_ok, safe_osc_active, reset_pin_in,
                uv_below_in}),
    .sync_out (sync_q)
  );

  assign uv_s   = sync_q[0];
  assign pin_s  = sync_q[1];
  assign safe_s = sync_q[2];
  assign ok_s   = sync_q[3];

  // -------------------------------------------------------------
  // decode
  // -------------------------------------------------------------
  // which register a strobe hits
  function automatic logic hit(input logic s, input logic [7:0] i,
                               input logic [7:0] r);
    hit = s && (i == r);
  endfunction

  always_comb begin
    wr_st   = hit(rb.wr, rb.idx, rcs_pkg::IDX_STATUS);
    rd_st   = hit(rb.rd, rb.idx, rcs_pkg::IDX_STATUS);
    wr_es   = hit(rb.wr, rb.idx, rcs_pkg::IDX_EVT_STS);
    wr_em   = hit(rb.wr, rb.idx, rcs_pkg::IDX_EVT_MASK);
    // detector off by strap: no undervoltage reset at all
    uv_now  = uv_s && uv_en_reg;                      // R4
    uv_rise = uv_now && !uv_act_reg;
    cf_rise = safe_s && !safe_prev_reg && css_en_reg;
    wdg_ev  = wdg_reset_pulse;
    evt_in  = '0;
    evt_in[rcs_pkg::EV_WDG] = wdg_ev;
    evt_in[rcs_pkg::EV_CF]  = cf_rise;
    evt_in[rcs_pkg::EV_UV]  = uv_rise;
  end

  // -------------------------------------------------------------
  // option straps, caught once after reset release
  // -------------------------------------------------------------
  always_comb begin
    opt_done_next = 1'b1;
    uv_en_next    = uv_en_reg;
    css_en_next   = css_en_reg;
    lvl_next      = lvl_reg;
    if (!opt_done_reg) begin
      uv_en_next  = opt_uv_enable;
      css_en_next = opt_css_enable;
      // an out-of-range code falls to the top level
      lvl_next    = (opt_uv_level > rcs_pkg::LVL_MAX)
                    ? rcs_pkg::LVL_MAX : opt_uv_level; // R13
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      opt_done_reg <= 1'b0;
      uv_en_reg    <= 1'b0;
      css_en_reg   <= 1'b0;
      lvl_reg      <= rcs_pkg::LVL_RST;
    end else begin
      opt_done_reg <= opt_done_next;
      uv_en_reg    <= uv_en_next;
      css_en_reg   <= css_en_next;
      lvl_reg      <= lvl_next;
    end
  end

  // -------------------------------------------------------------
  // status flags
  // -------------------------------------------------------------
  // hardware sets win over software clears in the same cycle; an undervoltage clear of the watchdog flag beats a watchdog set
  always_comb begin
    uv_act_next    = uv_now;
    safe_prev_next = safe_s;
    uvrf_next      = uvrf_reg;
    wdrf_next      = wdrf_reg;
    cfd_next       = cfd_reg;
    cfie_next      = cfie_reg;
    // undervoltage flag: only a zero write clears it
    if (uv_rise) begin
      uvrf_next = 1'b1;                               // R3
    end else if (wr_st && !rb.wdata[rcs_pkg::BIT_UVRF]) begin
      uvrf_next = 1'b0;                               // R3 R14
    end
    // watchdog flag; undervoltage wipes it, pin leaves it
    if (uv_rise) begin
      wdrf_next = 1'b0;                               // R9 R10
    end else if (wdg_ev) begin
      wdrf_next = 1'b1;                               // R9 R5
    end else if (wr_st && !rb.wdata[rcs_pkg::BIT_WDRF]) begin
      wdrf_next = 1'b0;                               // R9 R14
    end
    // clock fault flag, cleared by a read once recovered
    if (cf_rise) begin
      cfd_next = 1'b1;                                // R7
    end else if (rd_st && ok_s) begin
      cfd_next = 1'b0;                                // R7
    end
    if (!css_en_reg) begin
      cfd_next = 1'b0;                                // R8
    end
    if (wr_st) begin
      cfie_next = rb.wdata[rcs_pkg::BIT_CFIE];        // R6
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      uv_act_reg    <= 1'b0;
      safe_prev_reg <= 1'b0;
      uvrf_reg      <= rcs_pkg::FLAG_RST;
      wdrf_reg      <= rcs_pkg::FLAG_RST;
      cfd_reg       <= rcs_pkg::FLAG_RST;
      cfie_reg      <= rcs_pkg::FLAG_RST;
    end else begin
      uv_act_reg    <= uv_act_next;
      safe_prev_reg <= safe_prev_next;
      uvrf_reg      <= uvrf_next;
      wdrf_reg      <= wdrf_next;
      cfd_reg       <= cfd_next;
      cfie_reg      <= cfie_next;
    end
  end

  // -------------------------------------------------------------
  // interrupt and reset outputs
  // -------------------------------------------------------------
  always_comb begin
    // sticky events, write one to clear, new event wins
    evt_sts_next  = evt_sts_reg;
    if (wr_es) begin
      evt_sts_next = evt_sts_reg & ~rb.wdata[2:0];
    end
    evt_sts_next  = evt_sts_next | evt_in;
    evt_mask_next = wr_em ? rb.wdata[2:0] : evt_mask_reg;
    // fault enable has no effect with supervisor off
    irq_next = (|(evt_sts_next & evt_mask_next)) ||
               (cfd_next && cfie_next && css_en_reg); // R6
    core_rst_n_next = !(uv_now || !pin_s);            // R1
    pin_oe_next     = uv_now;                         // R2
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      evt_sts_reg    <= rcs_pkg::EVT_RST;
      evt_mask_reg   <= rcs_pkg::EVT_RST;
      irq_reg        <= 1'b0;
      core_rst_n_reg <= 1'b0;
      pin_oe_reg     <= 1'b0;
      osc_run_reg    <= 1'b1;
    end else begin
      evt_sts_reg    <= evt_sts_next;
      evt_mask_reg   <= evt_mask_next;
      irq_reg        <= irq_next;
      core_rst_n_reg <= core_rst_n_next;
      pin_oe_reg     <= pin_oe_next;
      // oscillator never stopped by any reset
      osc_run_reg    <= 1'b1;                         // R12
    end
  end

  // -------------------------------------------------------------
  // read mux and outputs
  // -------------------------------------------------------------
  always_comb begin
    rb.rdata = 8'h00;
    unique case (rb.idx)
      rcs_pkg::IDX_STATUS: begin
        // bits 7:5 and 3 stay zero
        rb.rdata[rcs_pkg::BIT_UVRF] = uvrf_reg;       // R11 R10
        rb.rdata[rcs_pkg::BIT_CFIE] = cfie_reg;
        rb.rdata[rcs_pkg::BIT_CFD]  = cfd_reg && css_en_reg; // R8
        rb.rdata[rcs_pkg::BIT_WDRF] = wdrf_reg;
      end
      rcs_pkg::IDX_EVT_STS:  rb.rdata[2:0] = evt_sts_reg;
      rcs_pkg::IDX_EVT_MASK: rb.rdata[2:0] = evt_mask_reg;
      default:               rb.rdata = 8'h00;
    endcase
  end

  assign core_reset_n  = core_rst_n_reg;
  assign reset_pin_out = 1'b0;      // open drain: only pulls low
  assign reset_pin_oe  = pin_oe_reg;
  assign irq           = irq_reg;
  assign osc_keep_run  = osc_run_reg;
  assign uv_level_sel  = lvl_reg;

  // -------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  core_held_a: assert property (uv_now |=> !core_reset_n) // R1
    else $error("core not in reset during undervoltage");
  pin_low_a: assert property (uv_now |=> reset_pin_oe) // R2
    else $error("reset pin not driven in undervoltage");
  uv_set_a: assert property (uv_rise |=> uvrf_reg && !wdrf_reg) // R3
    else $error("undervoltage flags wrong");
  uv_keep_a: assert property (uvrf_reg && !wr_st |=> uvrf_reg) // R5
    else $error("undervoltage flag lost");
  uv_one_a: assert property (!uvrf_reg && !uv_rise |=> !uvrf_reg) // R14
    else $error("undervoltage flag set by software");
  fault_irq_a: assert property (cfd_reg && cfie_reg && css_en_reg |-> irq) // R6
    else $error("clock fault interrupt missing");
  fault_set_a: assert property (cf_rise |=> cfd_reg) // R7
    else $error("clock fault flag not set");
  fault_clr_a: assert property (rd_st && ok_s && !cf_rise |=> !cfd_reg) // R7
    else $error("clock fault flag not cleared by read");
  fault_off_a: assert property (!css_en_reg |=> !cfd_reg) // R8
    else $error("clock fault flag set while off");
  wdg_set_a: assert property (wdg_ev && !uv_rise |=> wdrf_reg) // R9
    else $error("watchdog flag not set");
  rsv_zero_a: assert property (rb.idx == rcs_pkg::IDX_STATUS |->
    rb.rdata[7:5] == 3'h0 && !rb.rdata[3]) // R11
    else $error("reserved status bits not zero");
  osc_run_a: assert property (!core_reset_n |-> osc_keep_run) // R12
    else $error("oscillator stopped in reset");
  level_ok_a: assert property (uv_level_sel != 2'h3) // R13
    else $error("illegal threshold level");
  uv_cov_c:  cover property (uv_rise ##1 !core_reset_n);
  wdg_cov_c: cover property (wdg_ev ##[1:20] rd_st);
  cf_cov_c:  cover property (cf_rise ##[1:50] (rd_st && ok_s));
endmodule // rcs_top
`default_nettype wire

// File: bench/test_reset_source_and_clock_fault_status.sv
/*
  self-checking bench of the reset-source and clock-fault status block.
  assumes rcs_pkg and rcs_top are compiled first; one slave on the bus.
*/
`timescale 1ns/10ps
`default_nettype none
module test_reset_source_and_clock_fault_status;
  // ------------------------------------------------------------
  // design signals
  // ------------------------------------------------------------
  logic        clk_sys, reset_n, hsel, hwrite, hreadyout, hresp, irq;
  logic [1:0]  htrans, opt_uv_level, uv_level_sel;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic        uv_below_in, reset_pin_in, reset_pin_out, reset_pin_oe;
  logic        wdg_reset_pulse, safe_osc_active, main_osc_ok;
  logic        opt_uv_enable, opt_css_enable, core_reset_n, osc_keep_run;
  // model state, counters, seed
  int m_uv, m_wd, m_cf, m_ie, m_ev, m_mask, css_on, lv;
  int err_total, total_checks, cyc;
  int seed = 32'h6dcc;
  // byte addresses: index times four
  localparam logic [31:0] A_ST = {22'h0, rcs_pkg::IDX_STATUS, 2'h0};
  localparam logic [31:0] A_EV = {22'h0, rcs_pkg::IDX_EVT_STS, 2'h0};
  localparam logic [31:0] A_MK = {22'h0, rcs_pkg::IDX_EVT_MASK, 2'h0};
  localparam logic [31:0] A_NO = {22'h0, rcs_pkg::IDX_NONE, 2'h0};

  // single slave: its ready is the bus ready
  rcs_top uut (.clk_sys, .reset_n, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp,
    .hrdata, .uv_below_in, .reset_pin_in, .reset_pin_out, .reset_pin_oe,
    .wdg_reset_pulse, .safe_osc_active, .main_osc_ok, .opt_uv_enable,
    .opt_css_enable, .opt_uv_level, .core_reset_n, .osc_keep_run,
    .uv_level_sel, .irq);

  // ------------------------------------------------------------
  // clock and hang guard
  // ------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // whole run is well under 2000 cycles
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      end_sim();
    end
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // one single transfer; a spare edge first so no signal is set twice
  // waits are unbounded here: only the hang guard ends a stuck transfer
  task automatic bus(input logic w, input logic [31:0] a, d);
    @(posedge clk_sys);
    hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= w;
    do @(posedge clk_sys);
    while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do @(posedge clk_sys);
    while (hreadyout !== 1'b1);
    q = hrdata;
    chk(hresp, 1'b0);
  endtask
  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  // expected status word and interrupt level
  function automatic logic [31:0] st_exp();
    return {27'h0, m_uv[0], 1'b0, m_ie[0], m_cf[0], m_wd[0]};
  endfunction
  function automatic logic [31:0] irq_exp();
    return {31'h0, ((m_ev & m_mask) != 0) || (m_cf & m_ie & css_on) != 0};
  endfunction
  // watchdog event: one-cycle pulse
  task automatic wdg();
    @(posedge clk_sys) wdg_reset_pulse <= 1'b1;
    @(posedge clk_sys) wdg_reset_pulse <= 1'b0;
    wt(2);
    m_wd = 1; m_ev |= 1;
  endtask
  // power-on reset; straps are caught after release
  task automatic do_reset(input logic [1:0] l);
    reset_n <= 1'b0;
    wt(3);
    chk({core_reset_n, irq, reset_pin_oe, osc_keep_run}, 4'h1);
    reset_n <= 1'b1;
    wt(10);
    m_uv = 0; m_wd = 0; m_cf = 0; m_ie = 0; m_ev = 0; m_mask = 0;
    chk(core_reset_n, 1'b1);
    chk(uv_level_sel, (l == 2'h3) ? 2'h2 : l);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    reset_n = 0; hsel = 0; hwrite = 0; htrans = 0; haddr = 0; hwdata = 0;
    uv_below_in = 0; reset_pin_in = 1; wdg_reset_pulse = 0;
    safe_osc_active = 0; main_osc_ok = 1; opt_uv_enable = 1;
    opt_css_enable = 1; css_on = 1; lv = $random(seed);
    opt_uv_level = lv[1:0];
    err_total = 0; total_checks = 0; cyc = 0;
    do_reset(lv[1:0]);
    rdc(A_ST, st_exp());
    rdc(A_NO, 32'h0);
    // random mask contents read back, only three bits kept
    repeat (4) begin
      lv = $random(seed);
      bus(1'b1, A_MK, lv);
      m_mask = lv & 7;
      rdc(A_MK, m_mask);
    end
    bus(1'b1, A_MK, 32'h0);
    m_mask = 0;
    // watchdog sets its flag; ones never set, zero clears
    wdg();
    rdc(A_ST, st_exp());
    bus(1'b1, A_ST, 32'hff);
    m_ie = 1;
    rdc(A_ST, st_exp());
    bus(1'b1, A_ST, 32'h04);
    m_wd = 0;
    rdc(A_ST, st_exp());
    bus(1'b1, A_MK, 32'h1);
    m_mask = 1;
    chk(irq, irq_exp());
    rdc(A_EV, m_ev);
    bus(1'b1, A_EV, 32'h1);
    m_ev = 0;
    wt(1);
    chk(irq, irq_exp());
    // clock fault: sticky while main clock is still bad
    main_osc_ok <= 1'b0;
    safe_osc_active <= 1'b1;
    wt(8);
    m_cf = 1; m_ev |= 2;
    chk(irq, irq_exp());
    rdc(A_ST, st_exp());
    rdc(A_ST, st_exp());
    main_osc_ok <= 1'b1;
    safe_osc_active <= 1'b0;
    wt(8);
    rdc(A_ST, st_exp());
    m_cf = 0;
    rdc(A_ST, st_exp());
    bus(1'b1, A_EV, 32'h7);
    m_ev = 0;
    // undervoltage holds core and pin, clears watchdog flag
    wdg();
    uv_below_in <= 1'b1;
    wt(8);
    chk({core_reset_n, reset_pin_oe, reset_pin_out}, 3'h2);
    uv_below_in <= 1'b0;
    wt(8);
    m_uv = 1; m_wd = 0; m_ev |= 4;
    chk({core_reset_n, reset_pin_oe}, 2'h2);
    rdc(A_ST, st_exp());
    rdc(A_EV, m_ev);
    // pin and watchdog resets keep the undervoltage record
    reset_pin_in <= 1'b0;
    wt(8);
    chk(core_reset_n, 1'b0);
    reset_pin_in <= 1'b1;
    wt(8);
    wdg();
    rdc(A_ST, st_exp());
    bus(1'b1, A_ST, 32'h10);
    m_wd = 0; m_ie = 0;
    rdc(A_ST, st_exp());
    bus(1'b1, A_ST, 32'h00);
    m_uv = 0;
    rdc(A_ST, st_exp());
    // both supervisors strapped off, top level folded
    opt_css_enable <= 1'b0;
    opt_uv_enable <= 1'b0;
    opt_uv_level <= 2'h3;
    css_on = 0;
    do_reset(2'h3);
    bus(1'b1, A_ST, 32'h04);
    m_ie = 1;
    main_osc_ok <= 1'b0;
    safe_osc_active <= 1'b1;
    wt(8);
    rdc(A_ST, st_exp());
    chk(irq, irq_exp());
    uv_below_in <= 1'b1;
    wt(8);
    chk(core_reset_n, 1'b1);
    end_sim();
  end
endmodule // test_reset_source_and_clock_fault_status
`default_nettype wire
